// [fsa_pkg.sv]
// Purpose: Shared constants and types for the streaming acquisition sequencer.
// Assumes: Register offsets are word addresses on the documented register port.
// Notes:   Lengths are in samples per channel; each sample is two bytes.
package fsa_pkg;

    localparam logic [15:0] FSA_OFS_MODE    = 16'h251c;
    localparam logic [15:0] FSA_OFS_SEG_LEN = 16'h271a;
    localparam logic [15:0] FSA_OFS_REPEAT  = 16'h2724;
    localparam logic [15:0] FSA_OFS_PRE_CNT = 16'h272e;

    localparam logic [31:0] FSA_MODE_RING_RECORD = 32'h0000_0001;
    localparam logic [31:0] FSA_MODE_STREAM      = 32'h0000_0010;
    localparam logic [31:0] FSA_MODE_RESET       = 32'h0000_0000;

    localparam int          FSA_SAMPLE_W      = 16;
    localparam int          FSA_BYTES_PER_SMP = 2;
    localparam logic [2:0]  FSA_STEP_MASK     = 3'h7;
    localparam logic [63:0] FSA_PRE_MIN       = 64'h0000_0000_0000_0008;
    localparam logic [63:0] FSA_PRE_MAX_1CH   = 64'h0000_0000_0000_2000;
    localparam logic [63:0] FSA_PRE_MAX_2CH   = 64'h0000_0000_0000_1000;
    localparam logic [63:0] FSA_SEG_MIN       = 64'h0000_0000_0000_0010;
    localparam logic [63:0] FSA_SEG_MAX       = 64'h0000_0001_ffff_fff8;
    localparam logic [63:0] FSA_REPEAT_MAX    = 64'h0000_0000_ffff_ffff;
    localparam logic [63:0] FSA_REG_RESET     = 64'h0000_0000_0000_0000;
    localparam int          FSA_NOTIFY_BYTES  = 4096;

    typedef struct packed {
        logic                    valid;
        logic [FSA_SAMPLE_W-1:0] data;
    } fsa_sample_t;

    typedef enum logic [2:0] {
        FSA_IDLE    = 3'h0,
        FSA_PREFILL = 3'h1,
        FSA_ARMED   = 3'h3,
        FSA_STREAM  = 3'h2,
        FSA_DRAIN   = 3'h6
    } fsa_state_t;

endpackage

// [fsa_prebuf.sv]
// Purpose: Small pre-event sample buffer, first in first out.
// Assumes: The caller never pushes when full nor pops when empty.
// Notes:   Push and pop may happen in the same cycle.
`timescale 1ns/100ps
module fsa_prebuf #(
    parameter int DW = 16,
    parameter int AW = 13
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_flush,
    input  wire logic          i_push,
    input  wire logic [DW-1:0] i_data,
    input  wire logic          i_pop,
    output logic      [DW-1:0] o_data,
    output logic      [AW:0]   o_count
);
    logic [DW-1:0] mem [2**AW];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;

    assign cnt_next = cnt_reg + (AW+1)'(i_push) - (AW+1)'(i_pop);
    assign o_data   = mem[rd_reg];
    assign o_count  = cnt_reg;

    always_ff @(posedge i_sys_clk) begin
        if (i_push) begin
            mem[wr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || i_flush) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_reg + AW'(i_push);
            rd_reg  <= rd_reg + AW'(i_pop);
            cnt_reg <= cnt_next;
        end
    end
endmodule

// [fsa_stream_acq.sv]
// Purpose: Sequencer for continuous streaming acquisition into a sample FIFO toward host memory.
// Assumes: Samples, trigger and commands are synchronous to i_sys_clk; host DMA drains o_dma.
// Notes:   Registers are written only while idle; writes while running are ignored.
//
// Contract
// - Mode register value 10h selects continuous streaming toward host memory.
// - The whole on-board sample memory works as a FIFO in streaming mode.
// - Data drains to the host continuously while acquisition proceeds.
// - Pre-event count samples per channel are captured ahead of the trigger.
// - Segment length register gives samples per channel in one segment.
// - Stop after repeat count segments; zero repeat count runs until software stops.
// - Nonzero repeat count gives total samples of repeat count times segment length.
// - Pre-event samples live in a small dedicated pre-event buffer.
// - Each sample takes two bytes of on-board memory.
// - Minimum and post-event limits are fixed, independent of channels or memory.
// - Lengths must be aligned to the memory step, misaligned values are caught.
// - After start, fill the pre-event area first with trigger detection disarmed.
// - Block-available flag rises when a notify-size block is ready for the host.
// - Overflow flag rises when the on-board buffer overflows while streaming.
// - After overflow, acquisition stops but stored data still drains to host.
`timescale 1ns/100ps
module fsa_stream_acq
    import fsa_pkg::*;
#(
    parameter int MEM_AW = 27,
    parameter int PRE_AW = 13
) (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    input  wire logic [15:0]                   i_reg_addr,
    input  wire logic [63:0]                   i_reg_wdata,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    output logic      [63:0]                   o_reg_rdata,
    input  wire logic                          i_acq_start,
    input  wire logic                          i_acq_stop,
    input  wire logic                          i_xfer_start,
    input  wire logic                          i_two_channels,
    input  wire logic                          i_trigger,
    input  wire fsa_pkg::fsa_sample_t          i_smp,
    output fsa_pkg::fsa_sample_t               o_dma,
    input  wire logic                          i_dma_ready,
    output logic                               o_block_available_flag,
    output logic                               o_buffer_overflow_flag,
    output logic                               o_cfg_err,
    output logic                               o_acq_done,
    output logic                               o_busy,
    output logic                               o_armed
);
    import fsa_pkg::*;

    localparam logic [MEM_AW:0] MEM_DEPTH  = (MEM_AW+1)'(2**MEM_AW);
    localparam logic [63:0]     NOTIFY_SMP = 64'(FSA_NOTIFY_BYTES / FSA_BYTES_PER_SMP);

    // Length checks shared by the pre-event and segment length registers.
    function automatic logic len_ok(input logic [63:0] v, input logic [63:0] lo, input logic [63:0] hi);
        len_ok = (v >= lo) && (v <= hi) && ((v[2:0] & FSA_STEP_MASK) == 3'h0);
    endfunction

    logic [31:0]     mode_reg;
    logic [63:0]     seg_len_reg;
    logic [63:0]     repeat_reg;
    logic [63:0]     pre_cnt_reg;
    fsa_state_t      state_reg;
    fsa_state_t      state_next;
    logic [63:0]     seg_pos_reg;
    logic [63:0]     seg_done_reg;
    logic            xfer_en_reg;
    logic            ovf_reg;
    logic            err_reg;
    logic            done_reg;

    logic [FSA_SAMPLE_W-1:0] mem [2**MEM_AW];
    logic [MEM_AW-1:0]       mwr_reg;
    logic [MEM_AW-1:0]       mrd_reg;
    logic [MEM_AW:0]         mcnt_reg;
    fsa_sample_t             out_reg;

    wire logic        idle      = (state_reg == FSA_IDLE);
    wire logic        wr_cfg    = i_reg_wr && idle;
    wire logic [63:0] pre_max   = i_two_channels ? FSA_PRE_MAX_2CH : FSA_PRE_MAX_1CH;
    wire logic        mode_ok   = (mode_reg == FSA_MODE_STREAM);
    wire logic        cfg_ok    = mode_ok && len_ok(pre_cnt_reg, FSA_PRE_MIN, pre_max)
                                  && len_ok(seg_len_reg, FSA_SEG_MIN, FSA_SEG_MAX)
                                  && (repeat_reg <= FSA_REPEAT_MAX);
    wire logic        start_ok  = idle && i_acq_start && cfg_ok;
    wire logic        start_bad = idle && i_acq_start && !cfg_ok;

    // Pre-event buffer path.
    logic [FSA_SAMPLE_W-1:0] pre_q;
    logic [PRE_AW:0]         pre_fill;
    wire logic [63:0] pre_fill64 = 64'(pre_fill);
    wire logic        pre_full   = (pre_fill64 >= pre_cnt_reg);
    wire logic        in_pre     = (state_reg == FSA_PREFILL);
    wire logic        in_arm     = (state_reg == FSA_ARMED);
    wire logic        in_str     = (state_reg == FSA_STREAM);
    wire logic        pre_push   = i_smp.valid && ((in_pre && !pre_full) || in_arm || in_str);
    wire logic        pre_drop   = in_arm && i_smp.valid && pre_full;
    wire logic        pre_fwd    = in_str && (pre_fill != '0);
    wire logic        mem_full   = (mcnt_reg == MEM_DEPTH);
    wire logic        overflow   = pre_fwd && mem_full;
    wire logic        mem_push   = pre_fwd && !mem_full;

    // Segment and repeat counting on every sample that enters the sample FIFO.
    wire logic        seg_end    = mem_push && (seg_pos_reg + 64'h1 == seg_len_reg);
    wire logic        last_seg   = (repeat_reg != 64'h0) && (seg_done_reg + 64'h1 == repeat_reg);
    wire logic        acq_end    = seg_end && last_seg;

    // Drain toward the host whenever transfer is running and the output stage is free.
    wire logic        mem_empty  = (mcnt_reg == '0);
    wire logic        mem_pop    = xfer_en_reg && !mem_empty && (!out_reg.valid || i_dma_ready);
    wire logic        out_taken  = out_reg.valid && i_dma_ready;
    wire logic        drained    = (state_reg == FSA_DRAIN) && mem_empty && !out_reg.valid;

    fsa_prebuf #(
        .DW (FSA_SAMPLE_W),
        .AW (PRE_AW)
    ) u_prebuf (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_flush   (start_ok),
        .i_push    (pre_push),
        .i_data    (i_smp.data),
        .i_pop     (pre_drop || mem_push),
        .o_data    (pre_q),
        .o_count   (pre_fill)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FSA_IDLE: begin
                if (start_ok) begin
                    state_next = FSA_PREFILL;
                end
            end
            FSA_PREFILL: begin
                if (i_acq_stop) begin
                    state_next = FSA_DRAIN;
                end else if (pre_full) begin
                    state_next = FSA_ARMED;
                end
            end
            FSA_ARMED: begin
                if (i_acq_stop) begin
                    state_next = FSA_DRAIN;
                end else if (i_trigger) begin
                    state_next = FSA_STREAM;
                end
            end
            FSA_STREAM: begin
                if (i_acq_stop || overflow || acq_end) begin
                    state_next = FSA_DRAIN;
                end
            end
            FSA_DRAIN: begin
                if (drained) begin
                    state_next = FSA_IDLE;
                end
            end
            default: begin
                state_next = FSA_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_reg <= FSA_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Configuration registers; reads return the stored value.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            mode_reg    <= FSA_MODE_RESET;
            seg_len_reg <= FSA_REG_RESET;
            repeat_reg  <= FSA_REG_RESET;
            pre_cnt_reg <= FSA_REG_RESET;
        end else if (wr_cfg) begin
            if (i_reg_addr == FSA_OFS_MODE) begin
                mode_reg <= i_reg_wdata[31:0];
            end
            if (i_reg_addr == FSA_OFS_SEG_LEN) begin
                seg_len_reg <= i_reg_wdata;
            end
            if (i_reg_addr == FSA_OFS_REPEAT) begin
                repeat_reg <= i_reg_wdata;
            end
            if (i_reg_addr == FSA_OFS_PRE_CNT) begin
                pre_cnt_reg <= i_reg_wdata;
            end
        end
    end

    wire logic [63:0] rd_mux = (i_reg_addr == FSA_OFS_MODE)    ? 64'(mode_reg) :
                               (i_reg_addr == FSA_OFS_SEG_LEN) ? seg_len_reg   :
                               (i_reg_addr == FSA_OFS_REPEAT)  ? repeat_reg    :
                               (i_reg_addr == FSA_OFS_PRE_CNT) ? pre_cnt_reg   : 64'h0;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 64'h0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || start_ok) begin
            seg_pos_reg  <= 64'h0;
            seg_done_reg <= 64'h0;
        end else if (seg_end) begin
            seg_pos_reg  <= 64'h0;
            seg_done_reg <= seg_done_reg + 64'h1;
        end else if (mem_push) begin
            seg_pos_reg  <= seg_pos_reg + 64'h1;
        end
    end

    // Sample FIFO storage; 16-bit words, one per sample.
    always_ff @(posedge i_sys_clk) begin
        if (mem_push) begin
            mem[mwr_reg] <= pre_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || start_ok) begin
            mwr_reg  <= '0;
            mrd_reg  <= '0;
            mcnt_reg <= '0;
        end else begin
            mwr_reg  <= mwr_reg + MEM_AW'(mem_push);
            mrd_reg  <= mrd_reg + MEM_AW'(mem_pop);
            mcnt_reg <= mcnt_reg + (MEM_AW+1)'(mem_push) - (MEM_AW+1)'(mem_pop);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || start_ok) begin
            out_reg <= '0;
        end else if (mem_pop) begin
            out_reg.valid <= 1'b1;
            out_reg.data  <= mem[mrd_reg];
        end else if (out_taken) begin
            out_reg.valid <= 1'b0;
        end
    end

    // Transfer enable is dropped on return to idle, so each run needs a fresh transfer start.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || drained) begin
            xfer_en_reg <= 1'b0;
        end else if (i_xfer_start) begin
            xfer_en_reg <= 1'b1;
        end
    end

    // Overflow and config-error flags are cleared only by a new start, which cannot coincide with an overflow.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ovf_reg  <= 1'b0;
            err_reg  <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            ovf_reg  <= overflow || (ovf_reg && !start_ok);
            err_reg  <= start_bad || (err_reg && !start_ok);
            done_reg <= drained;
        end
    end

    assign o_dma                  = out_reg;
    assign o_block_available_flag = (64'(mcnt_reg) >= NOTIFY_SMP);
    assign o_buffer_overflow_flag = ovf_reg;
    assign o_cfg_err              = err_reg;
    assign o_acq_done             = done_reg;
    assign o_busy                 = !idle;
    assign o_armed                = in_arm;
endmodule

// [fsa_stream_acq_asserts.sv]
// Purpose: Port-level temporal checks for the streaming acquisition sequencer.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to every instance of the sequencer.
`timescale 1ns/100ps
module fsa_stream_acq_asserts
    import fsa_pkg::*;
(
    input wire logic                 i_sys_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_acq_start,
    input wire logic                 i_trigger,
    input wire logic                 i_dma_ready,
    input wire fsa_pkg::fsa_sample_t o_dma,
    input wire logic                 o_buffer_overflow_flag,
    input wire logic                 o_cfg_err,
    input wire logic                 o_acq_done,
    input wire logic                 o_busy,
    input wire logic                 o_armed
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    busy_on_start_a: assert property ($rose(o_busy) |-> $past(i_acq_start))
        else $error("Busy rose without a start");
    refuse_flag_a: assert property ($rose(o_cfg_err) |-> $past(i_acq_start) && !$past(o_busy) && !o_busy)
        else $error("Config error flag without a refused idle start");
    err_idle_a: assert property (o_cfg_err |-> !o_busy)
        else $error("Busy while the config error flag stands");
    armed_busy_a: assert property (o_armed |-> o_busy)
        else $error("Armed while idle");
    // Eight pre-event samples need at least eight cycles of busy before arming.
    prefill_first_a: assert property ($rose(o_armed) |-> $past(o_busy, 8))
        else $error("Armed before the pre-event area could fill");
    trig_disarm_a: assert property (o_armed && i_trigger |=> !o_armed && o_busy)
        else $error("Trigger while armed did not start streaming");
    dma_hold_a: assert property (o_dma.valid && !i_dma_ready |=> o_dma.valid && $stable(o_dma.data))
        else $error("Host word changed before it was taken");
    idle_quiet_a: assert property (!o_busy |-> !o_dma.valid)
        else $error("Host word offered while idle");
    done_idle_a: assert property (o_acq_done |-> !o_busy && $past(o_busy) ##1 !o_acq_done)
        else $error("Completion pulse malformed");
    ovf_sticky_a: assert property (o_buffer_overflow_flag && !i_acq_start |=> o_buffer_overflow_flag)
        else $error("Overflow flag dropped without a start");
    ovf_drain_a: assert property ($rose(o_buffer_overflow_flag) |-> o_busy)
        else $error("Overflow flagged with nothing left to drain");

    cover property ($fell(o_armed));
    cover property (o_acq_done);
    cover property ($rose(o_buffer_overflow_flag));
    cover property ($rose(o_cfg_err));
endmodule

bind fsa_stream_acq fsa_stream_acq_asserts fsa_stream_acq_asserts_inst (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_acq_start(i_acq_start), .i_trigger(i_trigger),
    .i_dma_ready(i_dma_ready), .o_dma(o_dma), .o_buffer_overflow_flag(o_buffer_overflow_flag),
    .o_cfg_err(o_cfg_err), .o_acq_done(o_acq_done), .o_busy(o_busy), .o_armed(o_armed));

// [fsa_host_dma.sv]
// Purpose: Host memory side of the transfer path, taking one word per accepted cycle.
// Assumes: Ready changes only just after a rising edge.
// Notes:   Slow mode stalls on a pseudo-random pattern to exercise the hold of host words.
`timescale 1ns/100ps
module fsa_host_dma (
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    input  wire logic i_slow,
    output logic      o_ready
);
    logic [7:0] lfsr_reg;
    logic [7:0] lfsr_next;

    assign lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            lfsr_reg <= 8'h1f;
            o_ready  <= 1'b0;
        end else begin
            lfsr_reg <= lfsr_next;
            o_ready  <= !i_slow || lfsr_reg[0];
        end
    end
endmodule

// [fsa_stream_acq_tb_top.sv]
// Purpose: Self-checking bench for the streaming acquisition sequencer.
// Assumes: Small memories (32-word FIFO, 16-word pre-event buffer) stand in for real sizes.
// Notes:   Inputs change at the falling edge; a monitor compares every host word in order.
`timescale 1ns/100ps
module fsa_stream_acq_tb_top;
    import fsa_pkg::*;
    logic        i_sys_clk, i_rst_n, i_reg_wr, i_reg_rd, i_acq_start, i_acq_stop;
    logic        i_xfer_start, i_two_channels, i_trigger, i_dma_ready, o_block_available_flag;
    logic        o_buffer_overflow_flag, o_cfg_err, o_acq_done, o_busy, o_armed, slow;
    logic [15:0] i_reg_addr;
    logic [63:0] i_reg_wdata, o_reg_rdata;
    fsa_sample_t i_smp, o_dma;
    logic [15:0] smp [0:63];
    logic [15:0] exp_q [$];
    int          n_mismatch, n_compared;
    // Refused configurations: mode, pre-event, segment, repeat, two channels.
    logic [63:0] t_mode [0:6] = '{64'h1, 64'h10, 64'h10, 64'h10, 64'h10, 64'h10, 64'h10};
    logic [63:0] t_pre  [0:6] = '{64'h8, 64'hc, 64'h0, 64'h8, 64'h1008, 64'h8, 64'h8};
    logic [63:0] t_seg  [0:6] = '{64'h10, 64'h10, 64'h10, 64'h8, 64'h10, 64'h14, 64'h10};
    logic [63:0] t_rep  [0:6] = '{64'h1, 64'h1, 64'h1, 64'h1, 64'h1, 64'h1, 64'h1_0000_0000};
    logic        t_two  [0:6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    fsa_stream_acq #(
        .MEM_AW (5),
        .PRE_AW (4)
    ) fsa_stream_acq_inst (
        .i_sys_clk              (i_sys_clk),
        .i_rst_n                (i_rst_n),
        .i_reg_addr             (i_reg_addr),
        .i_reg_wdata            (i_reg_wdata),
        .i_reg_wr               (i_reg_wr),
        .i_reg_rd               (i_reg_rd),
        .o_reg_rdata            (o_reg_rdata),
        .i_acq_start            (i_acq_start),
        .i_acq_stop             (i_acq_stop),
        .i_xfer_start           (i_xfer_start),
        .i_two_channels         (i_two_channels),
        .i_trigger              (i_trigger),
        .i_smp                  (i_smp),
        .o_dma                  (o_dma),
        .i_dma_ready            (i_dma_ready),
        .o_block_available_flag (o_block_available_flag),
        .o_buffer_overflow_flag (o_buffer_overflow_flag),
        .o_cfg_err              (o_cfg_err),
        .o_acq_done             (o_acq_done),
        .o_busy                 (o_busy),
        .o_armed                (o_armed)
    );
    fsa_host_dma fsa_host_dma_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_slow(slow), .o_ready(i_dma_ready));

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick();
        @(negedge i_sys_clk);
    endtask

    function automatic logic [15:0] lfsr16(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // An empty queue expects all-unknown, so any surplus word is a mismatch.
    always @(negedge i_sys_clk) begin
        if (i_rst_n && o_dma.valid === 1'b1 && i_dma_ready === 1'b1) begin
            chk({48'h0, o_dma.data}, exp_q.size() > 0 ? {48'h0, exp_q.pop_front()} : 64'hx);
        end
    end

    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        tick();
        i_reg_wr = 1'b0;
        // An idle edge between calls keeps a strobe from being re-assigned in one time step.
        tick();
    endtask

    task automatic rd(input logic [15:0] a, input logic [63:0] e);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        tick();
        i_reg_rd = 1'b0;
        tick();
        chk(o_reg_rdata, e);
    endtask

    task automatic cfg(input logic [63:0] m, input logic [63:0] p, input logic [63:0] s, input logic [63:0] r);
        wr(FSA_OFS_MODE, m);
        wr(FSA_OFS_PRE_CNT, p);
        wr(FSA_OFS_SEG_LEN, s);
        wr(FSA_OFS_REPEAT, r);
    endtask

    task automatic pulse(input int which);
        i_acq_start = (which == 0);
        i_trigger = (which == 1);
        i_acq_stop = (which == 2);
        i_xfer_start = (which == 3);
        tick();
        {i_acq_start, i_trigger, i_acq_stop, i_xfer_start} = 4'h0;
        tick();
    endtask

    task automatic send(input int first, input int n);
        for (int i = first; i < first + n; i++) begin
            i_smp = {1'b1, smp[i]};
            tick();
        end
        i_smp = '0;
    endtask

    task automatic wait_sig(input bit done);
        int k;
        for (k = 0; k < 3000 && (done ? o_acq_done !== 1'b1 : o_armed !== 1'b1); k++) tick();
        if (k == 3000) begin
            n_mismatch++;
            $display("Error at %0t: wait ran out", $time);
            finish_test();
        end
    endtask

    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_acq_start, i_acq_stop, i_xfer_start, i_trigger} = 7'h0;
        {i_two_channels, slow, i_reg_addr, i_reg_wdata, i_smp} = '0;
        smp[0] = 16'h001f;
        for (int i = 1; i < 64; i++) smp[i] = lfsr16(smp[i-1]);
        repeat (2) tick();
        i_rst_n = 1'b1;
        rd(FSA_OFS_MODE, FSA_MODE_RESET);
        rd(16'h0100, 64'h0);
        for (int i = 0; i < 7; i++) begin
            i_two_channels = t_two[i];
            cfg(t_mode[i], t_pre[i], t_seg[i], t_rep[i]);
            pulse(0);
            chk({o_cfg_err, o_busy}, 64'h2);
        end
        // Two segments of 16 with 3 samples pushed while armed, so the oldest 3 drop out.
        i_two_channels = 1'b1;
        slow = 1'b1;
        cfg(FSA_MODE_STREAM, 64'h8, 64'h10, 64'h2);
        rd(FSA_OFS_MODE, FSA_MODE_STREAM);
        rd(FSA_OFS_SEG_LEN, 64'h10);
        rd(FSA_OFS_REPEAT, 64'h2);
        rd(FSA_OFS_PRE_CNT, 64'h8);
        for (int i = 3; i < 35; i++) exp_q.push_back(smp[i]);
        pulse(0);
        chk({o_cfg_err, o_busy}, 64'h1);
        pulse(3);
        send(0, 8);
        wait_sig(1'b0);
        send(8, 3);
        pulse(1);
        send(11, 24);
        wait_sig(1'b1);
        chk(64'(exp_q.size()), 64'h0);
        // Endless run without transfer overflows the 32-word FIFO, then stops and drains.
        i_two_channels = 1'b0;
        slow = 1'b0;
        cfg(FSA_MODE_STREAM, 64'h8, 64'h10, 64'h0);
        for (int i = 0; i < 32; i++) exp_q.push_back(smp[i]);
        pulse(0);
        send(0, 8);
        wait_sig(1'b0);
        pulse(1);
        send(8, 40);
        wr(FSA_OFS_MODE, FSA_MODE_RING_RECORD);
        // A full 32-word FIFO is still far below one notify block, so block-available stays low.
        chk({o_buffer_overflow_flag, o_busy, o_dma.valid, o_block_available_flag}, 64'hc);
        pulse(2);
        pulse(3);
        wait_sig(1'b1);
        chk(64'(exp_q.size()), 64'h0);
        rd(FSA_OFS_MODE, FSA_MODE_STREAM);
        finish_test();
    end
endmodule
